// ==== common/eto_pkg.sv ====
/*
 * eto_pkg: register indices, field positions, reset values and frame
 * constants for the E1 transmit overhead control block.
 * Assumes an APB master with 32-bit data; byte address = 4 * index.
 */
package eto_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] ETO_IDX_PLA = 8'h24;
    localparam logic [7:0] ETO_IDX_PLB = 8'h25;
    localparam logic [7:0] ETO_IDX_PLC = 8'h26;
    localparam logic [7:0] ETO_IDX_MASK = 8'h28;
    localparam logic [7:0] ETO_IDX_IDLE = 8'h29;
    localparam logic [7:0] ETO_IDX_SA4 = 8'h2A;
    localparam logic [7:0] ETO_IDX_FRAMER_MODE_THREE = 8'h2F;
    localparam logic [7:0] ETO_IDX_CTRL = 8'h30;
    localparam logic [7:0] ETO_IDX_ICSEL = 8'h31;
    localparam logic [7:0] ETO_IDX_STAT = 8'h32;
    // reset values
    localparam logic [7:0] ETO_RST_PLA = 8'h9C;
    localparam logic [7:0] ETO_RST_PLB = 8'h03;
    localparam logic [7:0] ETO_RST_PLC = 8'h00;
    localparam logic [7:0] ETO_RST_REG8 = 8'h00;
    localparam logic [15:0] ETO_RST_CTRL = 16'h0000;
    localparam logic [31:0] ETO_RST_ICSEL = 32'h0000_0000;
    // pulse_level_line_ctl fields
    localparam int ETO_B_HIGH_POWER = 7;
    localparam int ETO_B_TRISTATE = 6;
    localparam int ETO_B_AUTO_TRI_DIS = 5;
    localparam logic [7:0] ETO_PLC_MASK = 8'hEF;
    // transparent_overhead_mask fields, sa4 at bit 4 down to sa8 at bit 0
    localparam int ETO_B_SERVICE_SPARE = 7;
    localparam int ETO_B_FAS_SPARE = 6;
    localparam int ETO_B_ALARM = 5;
    // framer_mode_three fields
    localparam int ETO_B_CMI_NO_PRECODE = 5;
    localparam int ETO_B_SA6_SYNC = 4;
    // control register fields
    localparam int ETO_B_FRAME_SEL = 0;
    localparam int ETO_B_SA_ACCESS = 1;
    localparam int ETO_B_LOOP_EN = 2;
    localparam int ETO_B_TS0_TRANSP = 3;
    localparam int ETO_B_ALARM_VAL = 4;
    localparam int ETO_B_CODE_LO = 5;
    localparam int ETO_B_RXFS_LO = 8;
    localparam int ETO_B_LOOP_CH_LO = 10;
    localparam logic [1:0] ETO_CODE_CMI = 2'h1;
    // status fields
    localparam int ETO_B_MF_FLAG = 0;
    localparam int ETO_B_SHORT = 1;
    // frame constants
    localparam logic [7:0] ETO_FAS_WORD = 8'h1B;
    localparam int ETO_SA_COUNT = 5;
    localparam int ETO_SUB_SEGS = 4;
    localparam int ETO_LEVEL_W = 5;

    typedef enum logic {ETO_SHP_IDLE, ETO_SHP_RUN} eto_shp_type;
endpackage

// ==== hdl/eto_pulse_shaper.sv ====
/*
 * eto_pulse_shaper: plays the four sub-pulse levels of one line mark.
 * Assumes start_in is a one-cycle pulse no more often than every four clocks.
 */
module eto_pulse_shaper
    import eto_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic polarity_in,
    input wire logic [ETO_SUB_SEGS*ETO_LEVEL_W-1:0] levels_in,
    output logic [ETO_LEVEL_W-1:0] level_out,
    output logic pos_out,
    output logic neg_out
);
    eto_shp_type state_r;
    eto_shp_type state_nxt;
    logic [1:0] seg_r;
    logic [1:0] seg_nxt;
    logic pol_r;
    logic [ETO_LEVEL_W-1:0] level_nxt;

    // next segment index, restart on each mark
    assign seg_nxt = start_in ? 2'h0 : 2'(seg_r + 2'h1);
    assign state_nxt = start_in ? ETO_SHP_RUN :
        (state_r == ETO_SHP_RUN && seg_r != 2'h3) ? ETO_SHP_RUN : ETO_SHP_IDLE;
    // segment k takes bits 5k+4..5k
    assign level_nxt = (state_nxt == ETO_SHP_RUN) ?
        levels_in[seg_nxt*ETO_LEVEL_W +: ETO_LEVEL_W] : '0;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= ETO_SHP_IDLE;
            seg_r <= 2'h0;
            pol_r <= 1'b0;
            level_out <= '0;
            pos_out <= 1'b0;
            neg_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            seg_r <= seg_nxt;
            if (start_in) begin
                pol_r <= polarity_in;
            end
            level_out <= level_nxt;
            pos_out <= (state_nxt == ETO_SHP_RUN) &&
                (start_in ? polarity_in : pol_r);
            neg_out <= (state_nxt == ETO_SHP_RUN) &&
                !(start_in ? polarity_in : pol_r);
        end
    end
endmodule

// ==== hdl/eto_tx_overhead.sv ====
/*
 * eto_tx_overhead: E1 transmit overhead control with APB registers,
 * time-slot 0 assembly, idle code insertion, Sa shadowing, pulse shaping.
 * Assumes tx_bit_strobe_in pulses once per line bit, at most every 4 clocks,
 * and system_data_in is valid with the strobe.
 */
// How it works
// - each line mark plays four 5-bit sub-pulse levels, first to fourth.
// - first level in bits 4..0 of register a, others follow upward.
// - the three pulse-level registers reset to 9C, 03 and 00 hex.
// - high-power bit raises driver current, levels untouched.
// - tristate bit floats analogue and digital outputs, freezes monitor status.
// - short on the line floats analogue outputs unless auto-tristate disabled.
// - service-word spare bit comes from system input when transparent.
// - FAS-word spare bit comes from system input when transparent.
// - remote alarm bit comes from system input when transparent.
// - each transparent Sa bit comes from system input, registers ignored.
// - channel loopback replaces the looped channel with the idle code.
// - selected idle channels carry the idle code, MSB first; channel 0 only when time-slot 0 transparent.
// - multiframe begin raises a flag and copies Sa registers to shadow.
// - shadow Sa sent in next multiframe unless time-slot 0 transparent.
// - Sa register bit 0 goes in frame 1, bit 7 in frame 15.
// - without reload, the same Sa contents are sent again.
// - CMI code 01 uses alternate-mark precoding unless the bit omits it.
// - Sa6 sync access only counts with a multiframe receive format.
// - Sa6 detection aligned to multiframe only when sync access set.
module eto_tx_overhead
    import eto_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic tx_bit_strobe_in,
    input wire logic system_data_in,
    input wire logic line_short_in,
    output logic tx_data_out,
    output logic mf_begin_out,
    output logic [ETO_LEVEL_W-1:0] line_level_out,
    output logic line_out_pos_out,
    output logic line_out_neg_out,
    output logic line_out_oe_out,
    output logic digital_line_out_pos_out,
    output logic digital_line_out_neg_out,
    output logic digital_oe_out,
    output logic line_high_power_out,
    output logic sa6_sync_aligned_out
);
    function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
        reg_hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) && (a[9:2] == idx);
    endfunction
    function automatic logic a_ok(input logic [11:0] a);
        a_ok = (a[1:0] == 2'h0) && (a[11:10] == 2'h0);
    endfunction

    logic [7:0] pla_r, plb_r, plc_r, mask_r, idle_r, framer_mode_three_r;
    logic [15:0] ctrl_r;
    logic [31:0] icsel_r;
    logic [7:0] sa_r [ETO_SA_COUNT];
    logic [8*ETO_SA_COUNT-1:0] sa_flat;
    logic [8*ETO_SA_COUNT-1:0] shadow_r;
    logic flag_r, flag_nxt, short_r;
    logic [2:0] bit_r;
    logic [4:0] ts_r;
    logic [3:0] frm_r;
    logic mark_pol_r;

    // apb decode
    wire setup = psel_in && !penable_in;
    wire wr = psel_in && penable_in && pwrite_in && pready_out;
    wire [7:0] wd = pwdata_in[7:0];
    wire wr_pla = wr && reg_hit(paddr_in, ETO_IDX_PLA);
    wire wr_plb = wr && reg_hit(paddr_in, ETO_IDX_PLB);
    wire wr_plc = wr && reg_hit(paddr_in, ETO_IDX_PLC);
    wire wr_mask = wr && reg_hit(paddr_in, ETO_IDX_MASK);
    wire wr_idle = wr && reg_hit(paddr_in, ETO_IDX_IDLE);
    wire wr_framer_mode_three = wr && reg_hit(paddr_in, ETO_IDX_FRAMER_MODE_THREE);
    wire wr_ctrl = wr && reg_hit(paddr_in, ETO_IDX_CTRL);
    wire wr_icsel = wr && reg_hit(paddr_in, ETO_IDX_ICSEL);
    wire wr_stat = wr && reg_hit(paddr_in, ETO_IDX_STAT);
    wire [7:0] sa_idx = 8'(paddr_in[9:2] - ETO_IDX_SA4);
    wire sa_sel = (a_ok(paddr_in)) && (paddr_in[9:2] >= ETO_IDX_SA4) &&
        (sa_idx < 8'(ETO_SA_COUNT));

    wire [7:0] stat_rd = {6'h00, short_r, flag_r};
    wire [31:0] rd_mux =
        reg_hit(paddr_in, ETO_IDX_PLA) ? {24'h0, pla_r} :
        reg_hit(paddr_in, ETO_IDX_PLB) ? {24'h0, plb_r} :
        reg_hit(paddr_in, ETO_IDX_PLC) ? {24'h0, plc_r} :
        reg_hit(paddr_in, ETO_IDX_MASK) ? {24'h0, mask_r} :
        reg_hit(paddr_in, ETO_IDX_IDLE) ? {24'h0, idle_r} :
        reg_hit(paddr_in, ETO_IDX_FRAMER_MODE_THREE) ? {24'h0, framer_mode_three_r} :
        reg_hit(paddr_in, ETO_IDX_CTRL) ? {16'h0, ctrl_r} :
        reg_hit(paddr_in, ETO_IDX_ICSEL) ? icsel_r :
        reg_hit(paddr_in, ETO_IDX_STAT) ? {24'h0, stat_rd} :
        sa_sel ? {24'h0, sa_r[sa_idx[2:0]]} : 32'h0;
    wire rd_ok = sa_sel || reg_hit(paddr_in, ETO_IDX_PLA) ||
        reg_hit(paddr_in, ETO_IDX_PLB) || reg_hit(paddr_in, ETO_IDX_PLC) ||
        reg_hit(paddr_in, ETO_IDX_MASK) || reg_hit(paddr_in, ETO_IDX_IDLE) ||
        reg_hit(paddr_in, ETO_IDX_FRAMER_MODE_THREE) || reg_hit(paddr_in, ETO_IDX_CTRL) ||
        reg_hit(paddr_in, ETO_IDX_ICSEL) || reg_hit(paddr_in, ETO_IDX_STAT);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= setup;
            pslverr_out <= setup && !rd_ok;
            prdata_out <= (setup && !pwrite_in) ? rd_mux : 32'h0;
        end
    end

    // register file
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pla_r <= ETO_RST_PLA;
            plb_r <= ETO_RST_PLB;
            plc_r <= ETO_RST_PLC;
            mask_r <= ETO_RST_REG8;
            idle_r <= ETO_RST_REG8;
            framer_mode_three_r <= ETO_RST_REG8;
            ctrl_r <= ETO_RST_CTRL;
            icsel_r <= ETO_RST_ICSEL;
        end else begin
            if (wr_pla) pla_r <= wd;
            if (wr_plb) plb_r <= wd;
            if (wr_plc) plc_r <= wd & ETO_PLC_MASK;
            if (wr_mask) mask_r <= wd;
            if (wr_idle) idle_r <= wd;
            if (wr_framer_mode_three) framer_mode_three_r <= wd;
            if (wr_ctrl) ctrl_r <= pwdata_in[15:0];
            if (wr_icsel) icsel_r <= pwdata_in;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < ETO_SA_COUNT; gi++) begin : g_sa
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    sa_r[gi] <= ETO_RST_REG8;
                end else if (wr && reg_hit(paddr_in, 8'(ETO_IDX_SA4 + gi))) begin
                    sa_r[gi] <= wd;
                end
            end
            assign sa_flat[8*gi +: 8] = sa_r[gi];
        end
    endgenerate

    // control fields
    wire tristate = plc_r[ETO_B_TRISTATE];
    wire auto_dis = plc_r[ETO_B_AUTO_TRI_DIS];
    wire ts0_transp = ctrl_r[ETO_B_TS0_TRANSP];
    wire [1:0] code_sel = ctrl_r[ETO_B_CODE_LO +: 2];
    wire [1:0] rx_fs = ctrl_r[ETO_B_RXFS_LO +: 2];
    wire [4:0] loop_ch = ctrl_r[ETO_B_LOOP_CH_LO +: 5];
    wire sa_live = ctrl_r[ETO_B_FRAME_SEL] && ctrl_r[ETO_B_SA_ACCESS] &&
        !ts0_transp;
    wire [19:0] levels = {plc_r[3:0], plb_r, pla_r};

    // frame position
    wire last_bit = (bit_r == 3'h7);
    wire last_ts = (ts_r == 5'h1F);
    wire mf_tick = tx_bit_strobe_in && last_bit && last_ts && (frm_r == 4'hF);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_r <= 3'h0;
            ts_r <= 5'h0;
            frm_r <= 4'h0;
        end else if (tx_bit_strobe_in) begin
            bit_r <= 3'(bit_r + 3'h1);
            if (last_bit) ts_r <= 5'(ts_r + 5'h1);
            if (last_bit && last_ts) frm_r <= 4'(frm_r + 4'h1);
        end
    end

    // time-slot 0 assembly
    wire fas_frame = !frm_r[0];
    wire [2:0] sa_k = 3'(bit_r - 3'h3);
    wire is_sa = !fas_frame && (bit_r >= 3'h3);
    wire sa_shadow_bit = shadow_r[8*sa_k + 32'(frm_r[3:1])];
    wire sa_int = sa_live ? sa_shadow_bit : 1'b1;
    wire ts0_int = fas_frame ? ((bit_r == 3'h0) ? 1'b1 : ETO_FAS_WORD[3'h7 - bit_r]) :
        (bit_r == 3'h0) ? 1'b1 :
        (bit_r == 3'h1) ? 1'b1 :
        (bit_r == 3'h2) ? ctrl_r[ETO_B_ALARM_VAL] : sa_int;
    wire transp_bit =
        (fas_frame && bit_r == 3'h0 && mask_r[ETO_B_FAS_SPARE]) ||
        (!fas_frame && bit_r == 3'h0 && mask_r[ETO_B_SERVICE_SPARE]) ||
        (!fas_frame && bit_r == 3'h2 && mask_r[ETO_B_ALARM]) ||
        (is_sa && mask_r[3'h4 - sa_k]);
    wire ts0_bit = (ts0_transp || transp_bit) ? system_data_in : ts0_int;
    wire idle_hit = (icsel_r[ts_r] && (ts_r != 5'h0 || ts0_transp)) ||
        (ctrl_r[ETO_B_LOOP_EN] && ts_r == loop_ch);
    wire idle_bit = idle_r[3'h7 - bit_r];
    wire out_bit = idle_hit ? idle_bit :
        (ts_r == 5'h0) ? ts0_bit : system_data_in;

    assign flag_nxt = mf_tick || (flag_r && !(wr_stat && pwdata_in[ETO_B_MF_FLAG]));
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_data_out <= 1'b0;
            shadow_r <= '0;
            flag_r <= 1'b0;
            mf_begin_out <= 1'b0;
        end else begin
            if (tx_bit_strobe_in) tx_data_out <= out_bit;
            if (mf_tick) shadow_r <= sa_flat;
            flag_r <= flag_nxt;
            mf_begin_out <= mf_tick;
        end
    end

    // line coding and drivers
    wire cmi_plain = (code_sel == ETO_CODE_CMI) && framer_mode_three_r[ETO_B_CMI_NO_PRECODE];
    wire mark = tx_bit_strobe_in && (out_bit || cmi_plain);
    wire pol = cmi_plain ? out_bit : !mark_pol_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mark_pol_r <= 1'b0;
            short_r <= 1'b0;
            line_out_oe_out <= 1'b0;
            digital_oe_out <= 1'b0;
            digital_line_out_pos_out <= 1'b0;
            digital_line_out_neg_out <= 1'b0;
            line_high_power_out <= 1'b0;
            sa6_sync_aligned_out <= 1'b0;
        end else begin
            if (mark && !cmi_plain) mark_pol_r <= !mark_pol_r;
            if (!tristate) short_r <= line_short_in;
            line_out_oe_out <= !tristate && !(short_r && !auto_dis);
            digital_oe_out <= !tristate;
            if (tx_bit_strobe_in) begin
                digital_line_out_pos_out <= mark && pol;
                digital_line_out_neg_out <= mark && !pol;
            end
            line_high_power_out <= plc_r[ETO_B_HIGH_POWER];
            sa6_sync_aligned_out <= framer_mode_three_r[ETO_B_SA6_SYNC] && rx_fs[1];
        end
    end

    eto_pulse_shaper u_shaper (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(mark),
        .polarity_in(pol),
        .levels_in(levels),
        .level_out(line_level_out),
        .pos_out(line_out_pos_out),
        .neg_out(line_out_neg_out)
    );

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_four_levels;
        line_level_out == $past(levels[4:0]) ##1 line_level_out == $past(levels[9:5])
        ##1 line_level_out == $past(levels[14:10]) ##1 line_level_out == $past(levels[19:15]);
    endsequence
    property p_sub_pulses;
        mark |=> s_four_levels;
    endproperty
    a_sub_pulses: assert property (p_sub_pulses) else $error("sub-pulse order");

    property p_reset_vals;
        !$past(rst_n_in) |-> pla_r == ETO_RST_PLA && plb_r == ETO_RST_PLB && plc_r == ETO_RST_PLC;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("pulse reset value");

    property p_tristate;
        tristate |=> !line_out_oe_out && !digital_oe_out;
    endproperty
    a_tristate: assert property (p_tristate) else $error("tristate not applied");

    property p_freeze;
        tristate && $past(tristate) |-> $stable(short_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("monitor not frozen");

    property p_auto_tri;
        short_r && !auto_dis |=> !line_out_oe_out;
    endproperty
    a_auto_tri: assert property (p_auto_tri) else $error("short not tristated");

    property p_shadow;
        mf_tick |=> flag_r && shadow_r == $past(sa_flat);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow copy missing");

    property p_idle;
        tx_bit_strobe_in && idle_hit |=> tx_data_out == $past(idle_bit);
    endproperty
    a_idle: assert property (p_idle) else $error("idle code not inserted");

    property p_spare;
        tx_bit_strobe_in && ts_r == 5'h0 && !idle_hit && bit_r == 3'h0 &&
            !fas_frame && mask_r[ETO_B_SERVICE_SPARE] |=>
            tx_data_out == $past(system_data_in);
    endproperty
    a_spare: assert property (p_spare) else $error("spare bit not passed");

    property p_sa_shadow;
        tx_bit_strobe_in && ts_r == 5'h0 && !idle_hit && is_sa && sa_live &&
            !mask_r[3'h4 - sa_k] |=> tx_data_out == $past(sa_shadow_bit);
    endproperty
    a_sa_shadow: assert property (p_sa_shadow) else $error("sa bit wrong");

    property p_sa6;
        ##1 sa6_sync_aligned_out == $past(framer_mode_three_r[ETO_B_SA6_SYNC] && rx_fs[1]);
    endproperty
    a_sa6: assert property (p_sa6) else $error("sa6 sync gating");
endmodule

// ==== bench/eto_line_partner.sv ====
/*
 * eto_line_partner: far-end line termination model.
 * Assumes it sees the analogue line pins and returns a short indication.
 */
module eto_line_partner (
    input wire logic clk_in,
    input wire logic short_req_in,
    input wire logic pos_in,
    input wire logic neg_in,
    input wire logic oe_in,
    output logic line_short_out,
    output logic [1:0] wire_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last_r = 2'b00;
    // released pins show the inverse of their last driven level
    assign wire_out = oe_in ? {pos_in, neg_in} : ~last_r;
    initial line_short_out = 1'b0;
    always @(posedge clk_in) begin
        if (oe_in) last_r <= {pos_in, neg_in};
        line_short_out <= short_req_in;
    end
endmodule

// ==== bench/testbench.sv ====
/*
 * testbench: reference model and stimulus for eto_tx_overhead.
 * Assumes APB word registers at four times the index and strobes every 4 clocks.
 */
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench
    import eto_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, rst_n_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h4EBE;
    logic pready, pslverr, err, strobe = 1'b0, sdata = 1'b0, short_req = 1'b0, short_line;
    logic txd, mfb, lp, ln, loe, dp, dn, doe, hp, s6a, mfd = 1'b0, last_pol, have_pol = 1'b0;
    logic lvl_on = 1'b0;
    logic [4:0] lvl;
    logic [1:0] lwire;
    logic [31:0] mir [int];
    logic [7:0] shadow [5] = '{default: 8'h00};
    int n_errors = 0, n_tests = 0, b = 0, ts = 0, fr = 0, n_mf = 0, seg = 0;

    eto_tx_overhead eto_tx_overhead_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .paddr_in(paddr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .tx_bit_strobe_in(strobe), .system_data_in(sdata), .line_short_in(short_line),
        .tx_data_out(txd), .mf_begin_out(mfb), .line_level_out(lvl), .line_out_pos_out(lp),
        .line_out_neg_out(ln), .line_out_oe_out(loe), .digital_line_out_pos_out(dp),
        .digital_line_out_neg_out(dn), .digital_oe_out(doe), .line_high_power_out(hp),
        .sa6_sync_aligned_out(s6a));
    eto_line_partner eto_line_partner_i (.clk_in(clk_in), .short_req_in(short_req),
        .pos_in(lp), .neg_in(ln), .oe_in(loe), .line_short_out(short_line), .wire_out(lwire));

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic exp_bit(input logic sd);
        logic [31:0] c, m;
        c = mir[ETO_IDX_CTRL];
        m = mir[ETO_IDX_MASK];
        if ((mir[ETO_IDX_ICSEL][ts] && (ts != 0 || c[3])) ||
            (c[ETO_B_LOOP_EN] && c[14:10] == ts))
            return mir[ETO_IDX_IDLE][7 - b];
        if (ts != 0 || c[3]) return sd;
        if (b == 0) return m[fr[0] ? ETO_B_SERVICE_SPARE : ETO_B_FAS_SPARE] ? sd : 1'b1;
        if (fr[0] == 1'b0) return ETO_FAS_WORD[7 - b];
        if (b == 1) return 1'b1;
        if (b == 2) return m[ETO_B_ALARM] ? sd : c[ETO_B_ALARM_VAL];
        if (m[7 - b]) return sd;
        return (c[0] && c[1] && !c[3]) ? shadow[b - 3][fr / 2] : 1'b1;
    endfunction

    function automatic logic [4:0] seg_lv(input int s);
        logic [19:0] v;
        v = {mir[ETO_IDX_PLC][3:0], mir[ETO_IDX_PLB][7:0], mir[ETO_IDX_PLA][7:0]};
        return v[5 * s +: 5];
    endfunction

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        paddr <= {2'b00, a, 2'b00};
        pwr <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk_in);
        pen <= 1'b1;
        do begin
            @(posedge clk_in);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 50) n_errors++;
        #2;
        if (w) mir[a] = d;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHK("slverr", 1'b0, err)
        `CHK("read", e, rd)
    endtask

    task automatic wait_mf(input int n);
        int k;
        k = 0;
        while (n_mf < n && k < 20000) begin
            @(posedge clk_in);
            k++;
        end
        if (k >= 20000) n_errors++;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // bit stream, one strobe every four clocks
    initial begin
        int k;
        k = 0;
        wait (rst_n_in);
        forever begin
            @(posedge clk_in);
            k++;
            strobe <= (k % 4 == 0);
            sdata <= ^rnd();
        end
    end

    // reference model compared with the outputs
    always @(posedge clk_in) begin : mon
        logic s, d, e;
        logic [31:0] c;
        s = strobe;
        d = sdata;
        #1;
        c = mir[ETO_IDX_CTRL];
        if (seg > 0 && lvl_on && loe === 1'b1) `CHK("level", seg_lv(seg), lvl)
        seg = (seg > 0 && seg < 3) ? seg + 1 : 0;
        if (s) begin
            e = exp_bit(d);
            `CHK("tx_data", e, txd)
            if (c[6:5] == ETO_CODE_CMI && mir[ETO_IDX_FRAMER_MODE_THREE][5]) begin
                `CHK("cmi", {e, ~e}, {dp, dn})
                have_pol = 1'b0;
            end else if (c[6:5] == 2'b00 && doe === 1'b1) begin
                `CHK("mark", e, dp | dn)
                if (e && have_pol) `CHK("polarity", ~last_pol, dp)
                if (e && loe === 1'b1) `CHK("line_pol", {dp, dn}, lwire)
                if (e) last_pol = dp;
                have_pol = have_pol | e;
            end else have_pol = 1'b0;
            if (e && lvl_on && loe === 1'b1) `CHK("level", seg_lv(0), lvl)
            if (e) seg = 1;
            mfd = (fr == 15 && ts == 31 && b == 7);
            b = (b + 1) % 8;
            if (b == 0) ts = (ts + 1) % 32;
            if (b == 0 && ts == 0) fr = (fr + 1) % 16;
        end
        `CHK("mf_begin", mfd, mfb)
        if (mfd) begin
            for (int k = 0; k < 5; k++) shadow[k] = mir[ETO_IDX_SA4 + k][7:0];
            n_mf++;
        end
        mfd = 1'b0;
    end

    initial begin
        repeat (90000) @(posedge clk_in);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        for (int i = ETO_IDX_PLA; i <= ETO_IDX_STAT; i++)
            mir[i] = (i == ETO_IDX_PLA) ? 32'h9C : (i == ETO_IDX_PLB) ? 32'h03 : 32'h00;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = ETO_IDX_PLA; i <= ETO_IDX_ICSEL; i++)
            if (i != 8'h27) rdchk(8'(i), mir[i]);
        apb(8'h27, 1'b0, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_data", 32'h0, rd)
        $display("test reset done");
        wr(ETO_IDX_PLA, rnd() & 32'hFF);
        wr(ETO_IDX_PLB, rnd() & 32'hFF);
        wr(ETO_IDX_PLC, (rnd() & 32'h0F) | 32'h10);
        for (int i = ETO_IDX_PLA; i <= ETO_IDX_PLC; i++)
            rdchk(8'(i), mir[i] & ((i == ETO_IDX_PLC) ? 32'hEF : 32'hFF));
        lvl_on = 1'b1;
        wr(ETO_IDX_IDLE, rnd() & 32'hFF);
        wr(ETO_IDX_ICSEL, 32'h1800_0019);
        wr(ETO_IDX_CTRL, 32'h0000_4414);
        wr(ETO_IDX_MASK, 32'h0000_00E5);
        repeat (3000) @(posedge clk_in);
        wr(ETO_IDX_CTRL, mir[ETO_IDX_CTRL] | 32'h3);
        for (int k = 0; k < 5; k++) wr(ETO_IDX_SA4 + 8'(k), rnd() & 32'hFF);
        $display("test setup done");
        wait_mf(1);
        rdchk(ETO_IDX_STAT, 32'h1);
        wr(ETO_IDX_STAT, 32'h1);
        rdchk(ETO_IDX_STAT, 32'h0);
        for (int k = 0; k < 5; k++) wr(ETO_IDX_SA4 + 8'(k), rnd() & 32'hFF);
        wr(ETO_IDX_PLC, mir[ETO_IDX_PLC] | 32'h80);
        repeat (3) @(posedge clk_in);
        `CHK("high_power", 1'b1, hp)
        wr(ETO_IDX_PLC, mir[ETO_IDX_PLC] | 32'h20);
        @(posedge clk_in);
        short_req <= 1'b1;
        repeat (8) @(posedge clk_in);
        `CHK("oe_kept", 1'b1, loe)
        wr(ETO_IDX_PLC, mir[ETO_IDX_PLC] & ~32'h20);
        repeat (8) @(posedge clk_in);
        `CHK("oe_short", 1'b0, loe)
        rdchk(ETO_IDX_STAT, 32'h2);
        wr(ETO_IDX_PLC, mir[ETO_IDX_PLC] | 32'h40);
        @(posedge clk_in);
        short_req <= 1'b0;
        repeat (8) @(posedge clk_in);
        `CHK("tristate", 2'b00, {loe, doe})
        rdchk(ETO_IDX_STAT, 32'h2);
        wr(ETO_IDX_PLC, mir[ETO_IDX_PLC] & ~32'h40);
        repeat (8) @(posedge clk_in);
        `CHK("drive_back", 2'b11, {loe, doe})
        $display("test line done");
        lvl_on = 1'b0;
        wr(ETO_IDX_FRAMER_MODE_THREE, 32'h20);
        wr(ETO_IDX_CTRL, mir[ETO_IDX_CTRL] | 32'h20);
        repeat (400) @(posedge clk_in);
        wr(ETO_IDX_CTRL, mir[ETO_IDX_CTRL] & ~32'h20);
        lvl_on = 1'b1;
        $display("test code done");
        wr(ETO_IDX_CTRL, mir[ETO_IDX_CTRL] | 32'h8);
        repeat (1100) @(posedge clk_in);
        wr(ETO_IDX_CTRL, mir[ETO_IDX_CTRL] & ~32'h8);
        $display("test ts0 done");
        for (int i = 0; i < 8; i++) begin
            wr(ETO_IDX_FRAMER_MODE_THREE, {27'h0, i[2], 4'h0});
            wr(ETO_IDX_CTRL, (mir[ETO_IDX_CTRL] & ~32'h300) | {22'h0, i[1:0], 8'h0});
            repeat (3) @(posedge clk_in);
            `CHK("sa6_sync", i[2] & i[1], s6a)
        end
        $display("test sa6 done");
        wait_mf(2);
        wr(ETO_IDX_MASK, 32'h0000_001A);
        wait_mf(3);
        repeat (4000) @(posedge clk_in);
        $display("test stream done");
        tally_and_finish();
    end
endmodule
